//--- register_write_protection.sv
// Purpose: write-protection gate in front of system control registers
// Assumes: single clock, byte register port, read data one cycle later
// Notes:   protected register contents leave on prot_regs
// Behaviour
// - Main protect bit 0 opens writes to clock modes 0-2 and power mode 3.
// - Main bit 1 opens power modes 0/2, chip selects, inverters, IO buffer.
// - Main bit 2 opens port 9 direction, port 9 pin 3-7 selects, both PLLs.
// - Second protect bit 7 opens clock mode 3.
// - Third protect bit 1 opens the three voltage control registers.
// - Key opens clock divider, flash, bus, chip-select bounds only at 0xAA.
// - The key is a full byte and is compared as a whole.
`timescale 1ns/100ps

`include "write_protect_consts.svh"

module register_write_protection
    import write_protect_pkg::*;
#(
    parameter int N_PROT = 36
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    input  wire bus_req_t                     bus_req,
    output logic [`WP_DATA_W-1:0]             rd_data,
    output logic [N_PROT-1:0][`WP_DATA_W-1:0] prot_regs
);

    localparam logic [`WP_ADDR_W-1:0] PROT_ADDR [N_PROT] = '{
        `ADDR_CLOCK_MODE_ZERO, `ADDR_CLOCK_MODE_ONE, `ADDR_CLOCK_MODE_TWO,
        `ADDR_POWER_MODE_THREE, `ADDR_POWER_MODE_ZERO, `ADDR_POWER_MODE_TWO,
        `ADDR_CHIP_SEL_OUT_A, `ADDR_CHIP_SEL_OUT_B, `ADDR_INVERTER_CTRL_A,
        `ADDR_INVERTER_CTRL_B, `ADDR_IO_BUFFER_CTRL, `ADDR_PORT9_DIRECTION,
        `ADDR_PORT9_FSEL_3, `ADDR_PORT9_FSEL_4, `ADDR_PORT9_FSEL_5,
        `ADDR_PORT9_FSEL_6, `ADDR_PORT9_FSEL_7, `ADDR_PLL_CTRL_A,
        `ADDR_PLL_CTRL_B, `ADDR_CLOCK_MODE_THREE, `ADDR_VOLT_REG_CTRL,
        `ADDR_LOW_VOLT_DET, `ADDR_VOLT_DOWN_MON, `ADDR_CLOCK_DIV_CTRL,
        `ADDR_FLASH_MODE_CTRL, `ADDR_PERIPH_BUS_LO, `ADDR_PERIPH_BUS_HI,
        `ADDR_FLASH_EXT_BUS_A, `ADDR_FLASH_EXT_BUS_D, `ADDR_EXT_BUS_A,
        `ADDR_EXT_BUS_B, `ADDR_EXT_BUS_C, `ADDR_EXT_BUS_D,
        `ADDR_CS_BOUNDARY_A, `ADDR_CS_BOUNDARY_B, `ADDR_CS_BOUNDARY_C
    };

    localparam group_t PROT_GROUP [N_PROT] = '{
        GRP_MAIN_CLOCK, GRP_MAIN_CLOCK, GRP_MAIN_CLOCK, GRP_MAIN_CLOCK,
        GRP_MAIN_POWER, GRP_MAIN_POWER, GRP_MAIN_POWER, GRP_MAIN_POWER,
        GRP_MAIN_POWER, GRP_MAIN_POWER, GRP_MAIN_POWER,
        GRP_MAIN_PORT, GRP_MAIN_PORT, GRP_MAIN_PORT, GRP_MAIN_PORT,
        GRP_MAIN_PORT, GRP_MAIN_PORT, GRP_MAIN_PORT, GRP_MAIN_PORT,
        GRP_SECOND_CLK3,
        GRP_THIRD_VOLT, GRP_THIRD_VOLT, GRP_THIRD_VOLT,
        GRP_KEY, GRP_KEY, GRP_KEY, GRP_KEY, GRP_KEY, GRP_KEY, GRP_KEY,
        GRP_KEY, GRP_KEY, GRP_KEY, GRP_KEY, GRP_KEY, GRP_KEY
    };

    // entries watched by the checks below
    localparam int IDX_CLK0  = 0;
    localparam int IDX_PWR0  = 4;
    localparam int IDX_PLLA  = 17;
    localparam int IDX_CLK3  = 19;
    localparam int IDX_VREG  = 20;
    localparam int IDX_CDIV  = 23;

    logic [`WP_DATA_W-1:0] key_q;
    logic [2:0]            main_q;
    logic                  second_q;
    logic                  third_q;
    logic                  key_open;
    logic [5:0]            grp_open;
    logic [`WP_DATA_W-1:0] prot_q [N_PROT];
    logic [`WP_DATA_W-1:0] rd_data_d;
    logic [`WP_DATA_W-1:0] rd_data_q;

    logic wr_key;
    logic wr_main;
    logic wr_second;
    logic wr_third;

    assign wr_key    = bus_req.wr && bus_req.addr == `ADDR_WRITE_KEY;
    assign wr_main   = bus_req.wr && bus_req.addr == `ADDR_PROTECT_MAIN;
    assign wr_second = bus_req.wr && bus_req.addr == `ADDR_PROTECT_SECOND;
    assign wr_third  = bus_req.wr && bus_req.addr == `ADDR_PROTECT_THIRD;

    // protection control registers are always writable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            key_q <= `RESET_CONTROL;
        end else if (wr_key) begin
            key_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_q   <= 3'h0;
            second_q <= 1'b0;
            third_q  <= 1'b0;
        end else begin
            if (wr_main) begin
                main_q <= bus_req.wdata[2:0];
            end
            if (wr_second) begin
                second_q <= bus_req.wdata[`BIT_SECOND_CLOCK3];
            end
            if (wr_third) begin
                third_q <= bus_req.wdata[`BIT_THIRD_VOLTAGE];
            end
        end
    end

    assign key_open = (key_q == `KEY_OPEN_VALUE);

    // one enable per group, ordered as the one-hot group codes
    assign grp_open = {key_open,
                       third_q,
                       second_q,
                       main_q[`BIT_MAIN_PORT],
                       main_q[`BIT_MAIN_POWER],
                       main_q[`BIT_MAIN_CLOCK]};

    generate
        for (genvar i = 0; i < N_PROT; i++) begin : g_prot
            logic hit;
            assign hit = bus_req.wr && bus_req.addr == PROT_ADDR[i];
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    prot_q[i] <= `RESET_PROTECTED;
                end else if (hit && |(grp_open & PROT_GROUP[i])) begin
                    prot_q[i] <= bus_req.wdata;
                end
            end
            assign prot_regs[i] = prot_q[i];
        end
    endgenerate

    // read mux; reserved bits and unmapped addresses read zero
    always_comb begin
        rd_data_d = 8'h00;
        if (bus_req.addr == `ADDR_WRITE_KEY) begin
            rd_data_d = key_q;
        end else if (bus_req.addr == `ADDR_PROTECT_MAIN) begin
            rd_data_d = {5'h00, main_q};
        end else if (bus_req.addr == `ADDR_PROTECT_SECOND) begin
            rd_data_d = {second_q, 7'h00};
        end else if (bus_req.addr == `ADDR_PROTECT_THIRD) begin
            rd_data_d = {6'h00, third_q, 1'b0};
        end
        for (int j = 0; j < N_PROT; j++) begin
            if (bus_req.addr == PROT_ADDR[j]) begin
                rd_data_d = prot_q[j];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= bus_req.rd ? rd_data_d : 8'h00;
        end
    end

    assign rd_data = rd_data_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    clk0_locked_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_CLOCK_MODE_ZERO && !main_q[0]
        |=> $stable(prot_q[IDX_CLK0]))
        else $error("clock mode zero changed while locked");

    pwr0_open_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_POWER_MODE_ZERO && main_q[1]
        |=> prot_q[IDX_PWR0] == $past(bus_req.wdata))
        else $error("power mode zero missed an open write");

    pll_gate_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_PLL_CTRL_A
        |=> prot_q[IDX_PLLA] == ($past(main_q[2]) ? $past(bus_req.wdata)
                                 : $past(prot_q[IDX_PLLA])))
        else $error("pll control a gate wrong");

    clk3_gate_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_CLOCK_MODE_THREE && !second_q
        |=> $stable(prot_q[IDX_CLK3]))
        else $error("clock mode three changed while locked");

    volt_gate_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_VOLT_REG_CTRL && third_q
        |=> prot_q[IDX_VREG] == $past(bus_req.wdata))
        else $error("voltage regulator missed an open write");

    key_gate_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_CLOCK_DIV_CTRL && key_q != 8'hAA
        |=> $stable(prot_q[IDX_CDIV]))
        else $error("clock divider changed without key");

    key_byte_a: assert property (
        wr_key |=> key_open == ($past(bus_req.wdata) == `KEY_OPEN_VALUE))
        else $error("key open state differs from the written byte");

    read_through_a: assert property (
        bus_req.rd && bus_req.addr == `ADDR_CLOCK_MODE_ZERO
        |=> rd_data == $past(prot_q[IDX_CLK0]))
        else $error("protected read returned wrong value");

    key_open_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_CLOCK_DIV_CTRL && key_open
        |=> prot_q[IDX_CDIV] == $past(bus_req.wdata))
        else $error("clock divider missed a keyed write");

    volt_locked_a: assert property (
        bus_req.wr && bus_req.addr == `ADDR_VOLT_REG_CTRL && !third_q
        |=> $stable(prot_q[IDX_VREG]))
        else $error("voltage regulator changed while locked");

    // read data stand one cycle only, so a bus or-tree sees zero otherwise
    rd_idle_a: assert property (
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("read data stood outside its cycle");

    key_miss_c: cover property (
        wr_key && bus_req.wdata != `KEY_OPEN_VALUE);
    clk3_open_c: cover property (
        bus_req.wr && bus_req.addr == `ADDR_CLOCK_MODE_THREE && second_q);
    open_write_c: cover property (
        wr_main ##1 bus_req.wr && bus_req.addr == `ADDR_CLOCK_MODE_ZERO);
    key_unlock_c: cover property (
        wr_key && bus_req.wdata == 8'hAA ##1
        bus_req.wr && bus_req.addr == `ADDR_CLOCK_DIV_CTRL);
    locked_write_c: cover property (
        bus_req.wr && bus_req.addr == `ADDR_CLOCK_MODE_THREE && !second_q);

endmodule

//--- write_protect_consts.svh
// Purpose: constants for the register write-protection gate
// Assumes: byte-wide register port, 20-bit byte address
// Notes:   definitions only
`ifndef WRITE_PROTECT_CONSTS_SVH
`define WRITE_PROTECT_CONSTS_SVH

`define WP_ADDR_W              20
`define WP_DATA_W              8

// protection control registers
`define ADDR_WRITE_KEY         20'h00007
`define ADDR_PROTECT_MAIN      20'h4004A
`define ADDR_PROTECT_THIRD     20'h4004C
`define ADDR_PROTECT_SECOND    20'h4405F

// field positions
`define BIT_MAIN_CLOCK         0
`define BIT_MAIN_POWER         1
`define BIT_MAIN_PORT          2
`define BIT_SECOND_CLOCK3      7
`define BIT_THIRD_VOLTAGE      1

`define KEY_OPEN_VALUE         8'hAA
`define RESET_CONTROL          8'h00
`define RESET_PROTECTED        8'h00

// protected registers
`define ADDR_CLOCK_MODE_ZERO   20'h40046
`define ADDR_CLOCK_MODE_ONE    20'h40047
`define ADDR_CLOCK_MODE_TWO    20'h4004D
`define ADDR_POWER_MODE_THREE  20'h40048
`define ADDR_POWER_MODE_ZERO   20'h40044
`define ADDR_POWER_MODE_TWO    20'h40053
`define ADDR_CHIP_SEL_OUT_A    20'h40070
`define ADDR_CHIP_SEL_OUT_B    20'h40071
`define ADDR_INVERTER_CTRL_A   20'h40072
`define ADDR_INVERTER_CTRL_B   20'h40073
`define ADDR_IO_BUFFER_CTRL    20'h40074
`define ADDR_PORT9_DIRECTION   20'h40075
`define ADDR_PORT9_FSEL_3      20'h40076
`define ADDR_PORT9_FSEL_4      20'h40077
`define ADDR_PORT9_FSEL_5      20'h40078
`define ADDR_PORT9_FSEL_6      20'h40079
`define ADDR_PORT9_FSEL_7      20'h4007A
`define ADDR_PLL_CTRL_A        20'h40020
`define ADDR_PLL_CTRL_B        20'h40021
`define ADDR_CLOCK_MODE_THREE  20'h4005A
`define ADDR_VOLT_REG_CTRL     20'h40060
`define ADDR_LOW_VOLT_DET      20'h40062
`define ADDR_VOLT_DOWN_MON     20'h40064
`define ADDR_CLOCK_DIV_CTRL    20'h00004
`define ADDR_FLASH_MODE_CTRL   20'h00008
`define ADDR_PERIPH_BUS_LO     20'h0001E
`define ADDR_PERIPH_BUS_HI     20'h0001F
`define ADDR_FLASH_EXT_BUS_A   20'h00010
`define ADDR_FLASH_EXT_BUS_D   20'h00011
`define ADDR_EXT_BUS_A         20'h00012
`define ADDR_EXT_BUS_B         20'h00013
`define ADDR_EXT_BUS_C         20'h00014
`define ADDR_EXT_BUS_D         20'h00015
`define ADDR_CS_BOUNDARY_A     20'h00016
`define ADDR_CS_BOUNDARY_B     20'h00017
`define ADDR_CS_BOUNDARY_C     20'h00018

`endif

//--- write_protect_pkg.sv
// Purpose: types for the register write-protection gate
// Assumes: write_protect_consts.svh gives the widths
// Notes:   none
`include "write_protect_consts.svh"

package write_protect_pkg;

    // which enable opens a protected register
    typedef enum logic [5:0] {
        GRP_MAIN_CLOCK  = 6'h01,
        GRP_MAIN_POWER  = 6'h02,
        GRP_MAIN_PORT   = 6'h04,
        GRP_SECOND_CLK3 = 6'h08,
        GRP_THIRD_VOLT  = 6'h10,
        GRP_KEY         = 6'h20
    } group_t;

    typedef struct packed {
        logic [`WP_ADDR_W-1:0] addr;
        logic [`WP_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } bus_req_t;

endpackage

//--- test_register_write_protection.sv
// Purpose: random self-checking bench for the write-protection gate
// Assumes: byte port, read data one cycle after the read strobe
// Notes:   a bench model tracks every register and every enable
`timescale 1ns/100ps

`include "write_protect_consts.svh"

module test_register_write_protection
    import write_protect_pkg::*;
;
    logic                          sys_clk;
    logic                          reset_n;
    bus_req_t                      bus_req;
    logic [`WP_DATA_W-1:0]         rd_data;
    logic [35:0][`WP_DATA_W-1:0]   prot_regs;
    int                            fail_count;
    int                            checks_done;
    int                            mdl [36];
    int                            m_main, m_second, m_third, m_key;
    logic [19:0] addr_tab [36] = '{`ADDR_CLOCK_MODE_ZERO,
        `ADDR_CLOCK_MODE_ONE, `ADDR_CLOCK_MODE_TWO, `ADDR_POWER_MODE_THREE,
        `ADDR_POWER_MODE_ZERO, `ADDR_POWER_MODE_TWO, `ADDR_CHIP_SEL_OUT_A,
        `ADDR_CHIP_SEL_OUT_B, `ADDR_INVERTER_CTRL_A, `ADDR_INVERTER_CTRL_B,
        `ADDR_IO_BUFFER_CTRL, `ADDR_PORT9_DIRECTION, `ADDR_PORT9_FSEL_3,
        `ADDR_PORT9_FSEL_4, `ADDR_PORT9_FSEL_5, `ADDR_PORT9_FSEL_6,
        `ADDR_PORT9_FSEL_7, `ADDR_PLL_CTRL_A, `ADDR_PLL_CTRL_B,
        `ADDR_CLOCK_MODE_THREE, `ADDR_VOLT_REG_CTRL, `ADDR_LOW_VOLT_DET,
        `ADDR_VOLT_DOWN_MON, `ADDR_CLOCK_DIV_CTRL, `ADDR_FLASH_MODE_CTRL,
        `ADDR_PERIPH_BUS_LO, `ADDR_PERIPH_BUS_HI, `ADDR_FLASH_EXT_BUS_A,
        `ADDR_FLASH_EXT_BUS_D, `ADDR_EXT_BUS_A, `ADDR_EXT_BUS_B,
        `ADDR_EXT_BUS_C, `ADDR_EXT_BUS_D, `ADDR_CS_BOUNDARY_A,
        `ADDR_CS_BOUNDARY_B, `ADDR_CS_BOUNDARY_C};
    logic [19:0] ctrl_tab [4] = '{`ADDR_PROTECT_MAIN, `ADDR_PROTECT_SECOND,
        `ADDR_PROTECT_THIRD, `ADDR_WRITE_KEY};

    register_write_protection #(.N_PROT(36)) dut (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .bus_req   (bus_req),
        .rd_data   (rd_data),
        .prot_regs (prot_regs)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // enable that opens protected register i in the model
    function automatic bit is_open(int i);
        if (i < 4) return m_main[0];
        if (i < 11) return m_main[1];
        if (i < 19) return m_main[2];
        if (i == 19) return m_second[7];
        if (i < 23) return m_third[1];
        return m_key == 8'hAA;
    endfunction

    function automatic int exp_read(logic [19:0] a);
        if (a == `ADDR_PROTECT_MAIN) return m_main;
        if (a == `ADDR_PROTECT_SECOND) return m_second;
        if (a == `ADDR_PROTECT_THIRD) return m_third;
        if (a == `ADDR_WRITE_KEY) return m_key;
        for (int i = 0; i < 36; i++) if (addr_tab[i] == a) return mdl[i];
        return 0;
    endfunction

    task automatic model_write(input logic [19:0] a, input logic [7:0] d);
        if (a == `ADDR_PROTECT_MAIN) m_main = d & 8'h07;
        if (a == `ADDR_PROTECT_SECOND) m_second = d & 8'h80;
        if (a == `ADDR_PROTECT_THIRD) m_third = d & 8'h02;
        if (a == `ADDR_WRITE_KEY) m_key = d;
        for (int i = 0; i < 36; i++) begin
            if (addr_tab[i] == a && is_open(i)) mdl[i] = d;
        end
    endtask

    task automatic compare(input logic [7:0] got, input int exp);
        checks_done++;
        if (got !== exp[7:0]) begin
            fail_count++;
            $display("CHECK FAILED %0t read got %h want %h", $time, got,
                     exp[7:0]);
        end
    endtask

    task automatic compare_reg(input int i, input logic [7:0] got,
                               input int exp);
        checks_done++;
        if (got !== exp[7:0]) begin
            fail_count++;
            $display("CHECK FAILED %0t reg %0d got %h want %h", $time, i,
                     got, exp[7:0]);
        end
    endtask

    // one strobe cycle, then one idle cycle in which results are checked
    task automatic access(input bit w, input logic [19:0] a,
                          input logic [7:0] d);
        int e;
        e = w ? 0 : exp_read(a);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= w;
        bus_req.rd <= !w;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        if (w) model_write(a, d);
        @(negedge sys_clk);
        compare(rd_data, e);
        for (int i = 0; i < 36; i++) begin
            compare_reg(i, prot_regs[i], mdl[i]);
        end
        @(posedge sys_clk);
    endtask

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        m_main = 0;
        m_second = 0;
        m_third = 0;
        m_key = 0;
        foreach (mdl[i]) mdl[i] = 0;
    endtask

    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        int r;
        int idx;
        logic [7:0] d;
        reset_n = 1'b0;
        bus_req = '0;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(32'h1302));
        do_reset();
        for (int n = 0; n < 900; n++) begin
            if (n == 450) do_reset();
            r = $urandom_range(8);
            idx = $urandom_range(35);
            d = 8'($urandom);
            case (r)
                0, 1, 2: access(1'b1, ctrl_tab[r], d);
                // full key or a one-bit miss of it
                3: access(1'b1, `ADDR_WRITE_KEY, $urandom_range(1) ? 8'hAA :
                          8'hAA ^ (8'h01 << $urandom_range(7)));
                4, 5: access(1'b1, addr_tab[idx], d);
                6: access(1'b0, addr_tab[idx], d);
                7: access(1'b0, ctrl_tab[idx % 4], d);
                default: access(n[0], 20'h3FFFF, d);
            endcase
        end
        complete_run();
    end

    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
endmodule
